// >>> core/apc_channel.sv
/*
 application parallel channel: host strobe commands over avalon-mm, output and
 input registers toward the peripheral with flags, event flip-flops, inhibit.
 assumes peripheral pulses are asynchronous and last at least two clk_sys cycles.
*/
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "apc_cfg.svh"
module apc_channel #(
  parameter logic [4:0] CHAN_ADDR = 5'h00,
  parameter int STROBE_CYC = `APC_STROBE_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [31:0] out_data,
  output logic [3:0] out_parity,
  output logic output_data_flag,
  output logic output_command_flag,
  output logic in_present,
  input wire logic [31:0] in_data,
  input wire logic [3:0] in_parity,
  input wire logic latch_normal,
  input wire logic latch_maint,
  input wire logic output_taken_pulse,
  input wire logic periph_int,
  input wire logic periph_srq,
  input wire logic periph_cherr,
  input wire logic host_inhibit,
  output logic periph_inhibit,
  input wire logic timing_mark_line_in,
  output logic timing_mark_line_out,
  output logic [2:0] addr_ack,
  output logic int_req,
  output logic srq_req,
  output logic err_int
);
  import apc_pkg::*;

  // odd parity per byte: parity bit makes the byte plus bit odd
  function automatic logic [3:0] odd_par(input logic [31:0] d);
    logic [3:0] p;
    p = '0;
    for (int i = 0; i < 4; i++) begin
      p[i] = ~^d[8*i +: 8];
    end
    return p;
  endfunction

  apc_state_t state_r;
  apc_cmd_t cmd_r;
  logic [4:0] cmd_addr_r;
  logic [31:0] hdata_r;
  logic [31:0] rdata_r;
  logic [3:0] reply_r;
  logic [31:0] in_reg_r;
  logic [3:0] in_par_r;
  logic lnorm_r;
  logic lmaint_r;
  logic int_r;
  logic srq_r;
  logic cherr_r;
  logic inhovr_r;
  logic inh_d_r;
  logic [31:0] maint_r;
  logic [4:0] chaddr_r;
  logic [7:0] cnt_r;
  logic lat_go;
  logic gate_ok_r;
  logic [4:0] rise;
  logic hit;
  logic lead;
  logic trail;
  logic [31:0] sel_bit;

  // peripheral pulses crossed into clk_sys before any flag moves
  apc_sync_pulse #(.W(5)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .din({latch_normal, latch_maint, output_taken_pulse, periph_int, periph_srq}),
    .rise(rise)
  );

  logic cherr_s1_r;
  logic cherr_s2_r;
  // channel error is a level; plain two-flop crossing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cherr_s1_r <= 1'b0;
      cherr_s2_r <= 1'b0;
    end else if (ce) begin
      cherr_s1_r <= periph_cherr;
      cherr_s2_r <= cherr_s1_r;
    end
  end

  // a write to the command register launches one strobe cycle
  assign lat_go = ce && avs_write && avs_address == `APC_ADDR_CMD && state_r == APC_ST_IDLE;
  assign hit = cmd_addr_r == chaddr_r;
  assign lead = ce && state_r == APC_ST_LEAD;
  assign trail = ce && state_r == APC_ST_TRAIL && cnt_r == 8'h00;
  assign sel_bit = 32'h1 << chaddr_r;

  // strobe sequencer: leading edge, held low, trailing edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= APC_ST_IDLE;
      cmd_r <= APC_CMD_NOP;
      cmd_addr_r <= 5'h00;
      cnt_r <= 8'h00;
    end else if (ce) begin
      case (state_r)
        APC_ST_IDLE: if (lat_go) begin
          cmd_r <= apc_cmd_t'(avs_writedata[3:0] > 4'hb ? 4'hb : avs_writedata[3:0]);
          cmd_addr_r <= avs_writedata[12:8];
          state_r <= APC_ST_LEAD;
        end
        APC_ST_LEAD: begin
          cnt_r <= 8'(STROBE_CYC - 1);
          state_r <= APC_ST_TRAIL;
        end
        APC_ST_TRAIL: if (cnt_r == 8'h00) begin
          state_r <= APC_ST_IDLE;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
        default: state_r <= APC_ST_IDLE;
      endcase
    end
  end

  // address acknowledges while the strobe is low and the address matches
  assign addr_ack = {3{state_r != APC_ST_IDLE && hit}};

  // output path: gated loads, flags set at trailing edge, cleared by taken
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_data <= 32'h0;
      out_parity <= 4'h0;
      output_data_flag <= 1'b0;
      output_command_flag <= 1'b0;
      gate_ok_r <= 1'b0;
    end else if (ce) begin
      if (lead && hit && (cmd_r == APC_CMD_OUTLOAD || cmd_r == APC_CMD_CMDLOAD)) begin
        gate_ok_r <= !output_data_flag && !output_command_flag;
        if (!output_data_flag && !output_command_flag) begin
          out_data <= hdata_r;
          out_parity <= odd_par(hdata_r);
        end
      end
      if (trail && hit && cmd_r == APC_CMD_RESET) begin
        output_data_flag <= 1'b0;
        output_command_flag <= 1'b0;
      end else if (rise[2]) begin
        output_data_flag <= 1'b0;
        output_command_flag <= 1'b0;
      end else if (trail && hit && gate_ok_r) begin
        if (cmd_r == APC_CMD_OUTLOAD) output_data_flag <= 1'b1;
        if (cmd_r == APC_CMD_CMDLOAD) output_command_flag <= 1'b1;
      end
    end
  end

  // input path runs apart from the output path; latch beats fetch clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      in_reg_r <= 32'h0;
      in_par_r <= 4'h0;
      lnorm_r <= 1'b0;
      lmaint_r <= 1'b0;
    end else if (ce) begin
      if (rise[4] || rise[3]) begin
        in_reg_r <= in_data;
        in_par_r <= in_parity;
      end
      // a fetch clears only what its reply reported, so a mid-strobe latch survives
      if (rise[4]) lnorm_r <= 1'b1;
      else if (trail && hit && (cmd_r == APC_CMD_RESET ||
          (cmd_r == APC_CMD_FETCH && reply_r[`APC_RPL_AGOOD])))
        lnorm_r <= 1'b0;
      if (rise[3]) lmaint_r <= 1'b1;
      else if (trail && hit && (cmd_r == APC_CMD_RESET ||
          (cmd_r == APC_CMD_FETCH && reply_r[`APC_RPL_ERRST])))
        lmaint_r <= 1'b0;
    end
  end
  // input present mirrors the latch flip-flops; peripheral waits on it
  assign in_present = lnorm_r | lmaint_r;

  // event flip-flops: set wins over read-clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      int_r <= 1'b0;
      srq_r <= 1'b0;
      cherr_r <= 1'b0;
    end else if (ce) begin
      if (rise[1]) int_r <= 1'b1;
      else if (trail && hit && cmd_r == APC_CMD_INTRDCLR) int_r <= 1'b0;
      if (rise[0]) srq_r <= 1'b1;
      else if (trail && hit && cmd_r == APC_CMD_SRQRDCLR) srq_r <= 1'b0;
      if (cherr_s2_r) cherr_r <= 1'b1;
      else if (trail && hit && cmd_r == APC_CMD_RESET) cherr_r <= 1'b0;
    end
  end
  assign int_req = int_r;
  assign srq_req = srq_r;
  assign err_int = cherr_r;

  // maintenance register, inhibit override and channel address
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      maint_r <= 32'h0;
      inhovr_r <= 1'b0;
      inh_d_r <= 1'b0;
      chaddr_r <= CHAN_ADDR;
    end else if (ce) begin
      // only the onset of inhibit drops the override, so diagnostics can set it after
      inh_d_r <= host_inhibit;
      if (host_inhibit && !inh_d_r) inhovr_r <= 1'b0;
      else if (avs_write && avs_address == `APC_ADDR_CTRL) begin
        inhovr_r <= avs_writedata[`APC_CT_INHOVR];
        chaddr_r <= avs_writedata[`APC_CT_CHADDR_LO +: 5];
      end
      if (lead && hit && cmd_r == APC_CMD_MENTRY) maint_r <= hdata_r;
      else if (trail && hit && cmd_r == APC_CMD_RESET) maint_r <= 32'h0;
    end
  end

  // inhibit forwarded, override masks it for diagnostics
  assign periph_inhibit = host_inhibit & ~inhovr_r;
  assign timing_mark_line_out = timing_mark_line_in;

  // host data word taken from avalon writes; read data and reply captured at the leading edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hdata_r <= 32'h0;
      rdata_r <= 32'h0;
      reply_r <= 4'h0;
    end else if (ce) begin
      if (avs_write && avs_address == `APC_ADDR_HDATA) hdata_r <= avs_writedata;
      if (lead) begin
        reply_r <= 4'h0;
        rdata_r <= 32'h0;
        if (hit) begin
          reply_r[`APC_RPL_ACK] <= 1'b1;
          case (cmd_r)
            APC_CMD_OUTLOAD, APC_CMD_CMDLOAD: begin
              reply_r[`APC_RPL_RDY] <= !output_data_flag && !output_command_flag;
              reply_r[`APC_RPL_AGOOD] <= !output_data_flag && !output_command_flag;
            end
            APC_CMD_FETCH: begin
              rdata_r <= in_reg_r;
              reply_r[`APC_RPL_RDY] <= lnorm_r | lmaint_r;
              reply_r[`APC_RPL_AGOOD] <= lnorm_r;
              reply_r[`APC_RPL_ERRST] <= lmaint_r;
            end
            APC_CMD_INTRDCLR: begin
              rdata_r <= {31'h0, int_r};
              reply_r[1:0] <= 2'b11;
            end
            APC_CMD_SRQRDCLR: begin
              rdata_r <= {31'h0, srq_r};
              reply_r[1:0] <= 2'b11;
            end
            APC_CMD_INTPOLL: begin
              rdata_r <= int_r ? sel_bit : 32'h0;
              reply_r[1:0] <= 2'b11;
            end
            APC_CMD_ERRPOLL: begin
              rdata_r <= cherr_r ? sel_bit : 32'h0;
              reply_r[1:0] <= 2'b11;
            end
            APC_CMD_SRQPOLL: begin
              rdata_r <= srq_r ? sel_bit : 32'h0;
              reply_r[1:0] <= 2'b11;
            end
            default: reply_r[1:0] <= 2'b11;
          endcase
        end
      end
    end
  end

  // avalon: command write waits while a strobe runs; others answer at once
  assign avs_waitrequest = avs_write && avs_address == `APC_ADDR_CMD && state_r != APC_ST_IDLE;
  always_comb begin
    case (avs_address)
      `APC_ADDR_HDATA: avs_readdata = hdata_r;
      `APC_ADDR_RDATA: avs_readdata = rdata_r;
      `APC_ADDR_REPLY: avs_readdata = {28'h0, reply_r};
      `APC_ADDR_STATUS: avs_readdata = {22'h0, maint_r != 32'h0, inhovr_r, cherr_r, srq_r,
        int_r, in_present, lmaint_r, lnorm_r, output_command_flag, output_data_flag};
      `APC_ADDR_CTRL: avs_readdata = {19'h0, chaddr_r, 7'h0, inhovr_r};
      `APC_ADDR_MAINT: avs_readdata = maint_r;
      `APC_ADDR_OUTREG: avs_readdata = out_data;
      `APC_ADDR_INREG: avs_readdata = in_reg_r;
      `APC_ADDR_CMD: avs_readdata = {28'h0, state_r != APC_ST_IDLE, 3'h0};
      default: avs_readdata = `APC_UNMAPPED_DATA;
    endcase
  end

  // checks
  sequence s_load_ok;
    lead && hit && cmd_r == APC_CMD_OUTLOAD && !output_data_flag && !output_command_flag;
  endsequence
  a_load_sets_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_load_ok ##1 (state_r == APC_ST_TRAIL)[*1] |-> ##[0:20] output_data_flag || rise[2])
    else $error("output data flag not set after load");
  a_blocked_keeps: assert property (@(posedge clk_sys) disable iff (!rstn)
    lead && hit && (cmd_r == APC_CMD_OUTLOAD || cmd_r == APC_CMD_CMDLOAD) &&
    (output_data_flag || output_command_flag) |=> $stable(out_data))
    else $error("output register changed while flag set");
  a_taken_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && rise[2] |=> !output_data_flag && !output_command_flag)
    else $error("taken pulse did not clear flags");
  a_latch_sets: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && rise[4] |=> lnorm_r && in_present)
    else $error("normal latch not recorded");
  a_fetch_reply: assert property (@(posedge clk_sys) disable iff (!rstn)
    lead && hit && cmd_r == APC_CMD_FETCH && lmaint_r |=> reply_r[`APC_RPL_ERRST])
    else $error("maintenance latch missed error-status reply");
  a_cherr_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    cherr_r && !(trail && hit && cmd_r == APC_CMD_RESET) |=> cherr_r)
    else $error("channel error dropped without reset");
  a_ack_match: assert property (@(posedge clk_sys) disable iff (!rstn)
    addr_ack != 3'h0 |-> hit && state_r != APC_ST_IDLE)
    else $error("address acknowledge without match");
  a_inhibit_fwd: assert property (@(posedge clk_sys) disable iff (!rstn)
    host_inhibit && !inhovr_r |-> periph_inhibit)
    else $error("inhibit not forwarded");
endmodule // apc_channel

// >>> core/apc_cfg.svh
/*
 register map, field positions and constants of the application parallel channel.
 assumes inclusion by the package, the design files and the testbench.
*/
`ifndef APC_CFG_SVH
`define APC_CFG_SVH
// register word addresses on the avalon slave
`define APC_ADDR_CMD 4'h0
`define APC_ADDR_HDATA 4'h1
`define APC_ADDR_RDATA 4'h2
`define APC_ADDR_REPLY 4'h3
`define APC_ADDR_STATUS 4'h4
`define APC_ADDR_CTRL 4'h5
`define APC_ADDR_MAINT 4'h6
`define APC_ADDR_OUTREG 4'h7
`define APC_ADDR_INREG 4'h8
// reply register fields
`define APC_RPL_RDY 0
`define APC_RPL_AGOOD 1
`define APC_RPL_ERRST 2
`define APC_RPL_ACK 3
// status register fields
`define APC_ST_ODATA 0
`define APC_ST_OCMD 1
`define APC_ST_LNORM 2
`define APC_ST_LMAINT 3
`define APC_ST_INPRES 4
`define APC_ST_INT 5
`define APC_ST_SRQ 6
`define APC_ST_CHERR 7
`define APC_ST_INHOVR 8
`define APC_ST_MAINT 9
// control register fields
`define APC_CT_INHOVR 0
`define APC_CT_CHADDR_LO 8
// strobe width in clocks between leading and trailing edge of a command
`define APC_STROBE_NS 100
`define APC_CLK_NS 50
`define APC_STROBE_CYC ((`APC_STROBE_NS + `APC_CLK_NS - 1) / `APC_CLK_NS)
`define APC_UNMAPPED_DATA 32'hdead_0000
`endif

// >>> core/apc_pkg.sv
/*
 types of the application parallel channel.
 assumes apc_cfg.svh is available on the include path.
*/
`include "apc_cfg.svh"
package apc_pkg;
  // twelve host commands, one active-low strobe each
  typedef enum logic [3:0] {
    APC_CMD_OUTLOAD,
    APC_CMD_CMDLOAD,
    APC_CMD_FETCH,
    APC_CMD_MENTRY,
    APC_CMD_RESET,
    APC_CMD_INTRDCLR,
    APC_CMD_SRQRDCLR,
    APC_CMD_INTPOLL,
    APC_CMD_ERRPOLL,
    APC_CMD_SRQPOLL,
    APC_CMD_STATUS,
    APC_CMD_NOP
  } apc_cmd_t;
  typedef enum logic [1:0] {
    APC_ST_IDLE,
    APC_ST_LEAD,
    APC_ST_TRAIL
  } apc_state_t;
endpackage

// >>> core/apc_sync_pulse.sv
/*
 two-flop synchroniser with rising-edge pulse out, vector wide.
 assumes inputs are asynchronous levels held at least two clocks.
*/
`timescale 1ns/1ps
module apc_sync_pulse #(
  parameter int W = 5
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] rise
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // first stage only feeds the second
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign rise = s2_r & ~s3_r & {W{ce}};
endmodule // apc_sync_pulse

// >>> verification/apc_periph_model.sv
/*
 peripheral-side model for the application parallel channel: loads the input
 register, takes the output word and raises the event leads.
 assumes its tasks are called at a rising edge of clk_sys.
*/
`timescale 1ns/1ps
module apc_periph_model (
  input wire logic clk_sys,
  input wire logic [31:0] out_data,
  input wire logic [3:0] out_parity,
  input wire logic output_data_flag,
  input wire logic output_command_flag,
  input wire logic in_present,
  output logic [31:0] in_data,
  output logic [3:0] in_parity,
  output logic latch_normal,
  output logic latch_maint,
  output logic output_taken_pulse,
  output logic [2:0] ev
);
  logic [35:0] got;

  // data leads have no pull, so they idle on a pattern rather than zero
  initial begin
    in_data = 32'h5a5a_a5a5;
    in_parity = 4'h3;
    latch_normal = 1'b0;
    latch_maint = 1'b0;
    output_taken_pulse = 1'b0;
    ev = 3'h0;
    got = 36'h0;
  end

  // load a word; normal latch for data, maintenance latch for status
  task automatic latch(input logic [31:0] w, input logic maint);
    int n;
    n = 0;
    // wait up to 400 clocks for the host to fetch the previous word before overwriting it
    while (in_present !== 1'b0 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    in_data <= w;
    in_parity <= ~{^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]};
    @(posedge clk_sys);
    if (maint)
      latch_maint <= 1'b1;
    else
      latch_normal <= 1'b1;
    repeat (3) @(posedge clk_sys);
    latch_normal <= 1'b0;
    latch_maint <= 1'b0;
    // hold the word past the synchroniser delay, then let it go stale
    repeat (4) @(posedge clk_sys);
    in_data <= ~w;
    in_parity <= ~in_parity;
  endtask

  // sample the output leads after a chosen delay, then acknowledge
  task automatic take(input int slow);
    int n;
    n = 0;
    while ((output_data_flag | output_command_flag) !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (slow) @(posedge clk_sys);
    got = {out_parity, out_data};
    output_taken_pulse <= 1'b1;
    repeat (3) @(posedge clk_sys);
    output_taken_pulse <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // event lead k: 0 interrupt, 1 service request, 2 channel error
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ev[k] <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // apc_periph_model

// >>> verification/test_application_parallel_channel.sv
/*
 self-checking bench of the application parallel channel.
 assumes the peripheral model file and apc_cfg.svh are compiled alongside.
*/
`timescale 1ns/1ps
`include "apc_cfg.svh"
module test_application_parallel_channel;
  import apc_pkg::*;
  localparam logic [4:0] CA = 5'h03;
  localparam logic [31:0] W1 = 32'h8001_00fe;
  localparam logic [31:0] W2 = 32'h1234_5678;
  logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, out_parity, in_parity;
  logic [31:0] avs_writedata, avs_readdata, out_data, in_data, rp, rd;
  logic output_data_flag, output_command_flag, in_present, latch_normal, latch_maint;
  logic output_taken_pulse, host_inhibit, periph_inhibit, tmark, tmark_out;
  logic int_req, srq_req, err_int;
  logic [2:0] ev, addr_ack;
  int fails, checks;

  apc_channel #(.CHAN_ADDR(CA)) u_dut (.clk_sys, .rstn, .ce(1'b1), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .out_data,
    .out_parity, .output_data_flag, .output_command_flag, .in_present, .in_data,
    .in_parity, .latch_normal, .latch_maint, .output_taken_pulse, .periph_int(ev[0]),
    .periph_srq(ev[1]), .periph_cherr(ev[2]), .host_inhibit, .periph_inhibit,
    .timing_mark_line_in(tmark), .timing_mark_line_out(tmark_out), .addr_ack,
    .int_req, .srq_req, .err_int);

  apc_periph_model u_per (.clk_sys, .out_data, .out_parity, .output_data_flag,
    .output_command_flag, .in_present, .in_data, .in_parity, .latch_normal,
    .latch_maint, .output_taken_pulse, .ev);

  // 20 mhz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [3:0] par(input logic [31:0] w);
    return ~{^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 50)
      fails++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  // issue a strobe command, watch the acknowledges mid-strobe, fetch the reply
  task automatic cmd(input apc_cmd_t c, input logic [4:0] a);
    bus(1'b1, `APC_ADDR_CMD, {19'h0, a, 4'h0, c});
    #1;
    chk(32'(addr_ack), (a == CA) ? 32'h7 : 32'h0);
    repeat (4) @(posedge clk_sys);
    bus(1'b0, `APC_ADDR_REPLY, 32'h0);
    rp = rd;
  endtask

  // every command under a foreign channel address must do nothing
  task automatic t_addr();
    for (int i = 0; i < 12; i++) begin
      bus(1'b1, `APC_ADDR_HDATA, 32'h1);
      cmd(apc_cmd_t'(i), CA ^ 5'h01);
      chk(32'(rp[3]), 32'h0);
    end
    bus(1'b0, `APC_ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 4'h9, 32'h0);
    chk(rd, `APC_UNMAPPED_DATA);
  endtask

  // output register gating by both flags, refusals while a word waits
  task automatic t_outpath();
    bus(1'b1, `APC_ADDR_HDATA, W1);
    cmd(APC_CMD_OUTLOAD, CA);
    chk(32'(rp[3:0]), 32'hb);
    chk(out_data, W1);
    chk(32'(out_parity), 32'(par(W1)));
    chk(32'({output_data_flag, output_command_flag}), 32'h2);
    bus(1'b1, `APC_ADDR_HDATA, W2);
    cmd(APC_CMD_CMDLOAD, CA);
    chk(32'(rp[0]), 32'h0);
    chk(out_data, W1);
    u_per.take(5);
    chk(u_per.got[31:0], W1);
    chk(32'({output_data_flag, output_command_flag}), 32'h0);
    cmd(APC_CMD_CMDLOAD, CA);
    chk(32'(rp[3:0]), 32'hb);
    chk(32'({output_data_flag, output_command_flag}), 32'h1);
    cmd(APC_CMD_OUTLOAD, CA);
    chk(32'(rp[0]), 32'h0);
    u_per.take(0);
    chk(32'(u_per.got[35:32]), 32'(par(W2)));
    chk(32'({output_data_flag, output_command_flag}), 32'h0);
  endtask

  // input path, both latch kinds, while an output word still waits
  task automatic t_inpath();
    cmd(APC_CMD_FETCH, CA);
    chk(32'(rp[0]), 32'h0);
    bus(1'b1, `APC_ADDR_HDATA, W1);
    cmd(APC_CMD_OUTLOAD, CA);
    for (int m = 0; m < 2; m++) begin
      u_per.latch(W2 ^ 32'(m), m[0]);
      chk(32'({in_present, output_data_flag}), 32'h3);
      bus(1'b0, `APC_ADDR_STATUS, 32'h0);
      chk(32'(rd[3:2]), m ? 32'h2 : 32'h1);
      cmd(APC_CMD_FETCH, CA);
      chk(32'(rp[3:0]), m ? 32'hd : 32'hb);
      bus(1'b0, `APC_ADDR_RDATA, 32'h0);
      chk(rd, W2 ^ 32'(m));
      chk(32'(in_present), 32'h0);
    end
    u_per.take(2);
    chk(u_per.got[31:0], W1);
  endtask

  // event flip-flops: polls keep them, read-clears drop them
  task automatic t_events();
    for (int k = 0; k < 3; k++) u_per.pulse(k);
    chk(32'({err_int, srq_req, int_req}), 32'h7);
    cmd(APC_CMD_INTPOLL, CA);
    bus(1'b0, `APC_ADDR_RDATA, 32'h0);
    chk(32'({rd[CA], int_req}), 32'h3);
    cmd(APC_CMD_ERRPOLL, CA);
    bus(1'b0, `APC_ADDR_RDATA, 32'h0);
    chk(32'(rd[CA]), 32'h1);
    cmd(APC_CMD_SRQPOLL, CA);
    bus(1'b0, `APC_ADDR_RDATA, 32'h0);
    chk(32'({rd[CA], srq_req}), 32'h3);
    cmd(APC_CMD_INTRDCLR, CA);
    bus(1'b0, `APC_ADDR_RDATA, 32'h0);
    chk(32'({rd[0], int_req}), 32'h2);
    cmd(APC_CMD_SRQRDCLR, CA);
    bus(1'b0, `APC_ADDR_RDATA, 32'h0);
    chk(32'({rd[0], srq_req}), 32'h2);
    cmd(APC_CMD_SRQPOLL, CA);
    cmd(APC_CMD_STATUS, CA);
    cmd(APC_CMD_NOP, CA);
    chk(32'(err_int), 32'h1);
  endtask

  // maintenance entry and the reset command
  task automatic t_clear();
    bus(1'b1, `APC_ADDR_HDATA, 32'h5);
    cmd(APC_CMD_MENTRY, CA);
    bus(1'b0, `APC_ADDR_STATUS, 32'h0);
    chk(32'(rd[9]), 32'h1);
    bus(1'b0, `APC_ADDR_MAINT, 32'h0);
    chk(rd, 32'h5);
    bus(1'b1, `APC_ADDR_HDATA, 32'h0);
    cmd(APC_CMD_MENTRY, CA);
    bus(1'b0, `APC_ADDR_STATUS, 32'h0);
    chk(32'(rd[9]), 32'h0);
    bus(1'b1, `APC_ADDR_HDATA, W1);
    cmd(APC_CMD_OUTLOAD, CA);
    u_per.latch(W2, 1'b0);
    bus(1'b1, `APC_ADDR_HDATA, 32'h5);
    cmd(APC_CMD_MENTRY, CA);
    bus(1'b0, `APC_ADDR_STATUS, 32'h0);
    chk(rd & 32'h29f, 32'h295);
    cmd(APC_CMD_RESET, CA);
    bus(1'b0, `APC_ADDR_STATUS, 32'h0);
    chk(rd & 32'h29f, 32'h0);
    chk(32'({err_int, output_data_flag, in_present}), 32'h0);
  endtask

  // inhibit forwarding with its override, timing mark passthrough
  task automatic t_pins();
    bus(1'b1, `APC_ADDR_CTRL, {19'h0, CA, 8'h01});
    bus(1'b0, `APC_ADDR_STATUS, 32'h0);
    chk(32'(rd[8]), 32'h1);
    for (int i = 0; i < 2; i++) begin
      host_inhibit <= i[0];
      tmark <= ~i[0];
      repeat (3) @(posedge clk_sys);
      chk(32'({periph_inhibit, tmark_out}), i ? 32'h2 : 32'h1);
    end
    bus(1'b0, `APC_ADDR_STATUS, 32'h0);
    chk(32'(rd[8]), 32'h0);
    // override set while inhibit stands must hide it from the peripheral
    bus(1'b1, `APC_ADDR_CTRL, {19'h0, CA, 8'h01});
    chk(32'(periph_inhibit), 32'h0);
    host_inhibit <= 1'b0;
  endtask

  task automatic conclude();
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence: three clocks of reset, then the scenarios
  initial begin
    fails = 0;
    checks = 0;
    rstn = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    host_inhibit = 1'b0;
    tmark = 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_addr();
    t_outpath();
    t_inpath();
    t_events();
    t_clear();
    t_pins();
    conclude();
  end

  // watchdog, well beyond the few hundred cycles the scenarios need
  initial begin
    #2000000;
    fails++;
    conclude();
  end
endmodule // test_application_parallel_channel
